// ===== src/ofs_pkg.sv
`default_nettype none
package ofs_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CODE_BASE_OFS = 8'h00;
  localparam logic [7:0] THR_OFS       = 8'h20;
  localparam logic [7:0] BAND_OFS      = 8'h24;
  localparam logic [7:0] STAT_OFS      = 8'h28;
  localparam int         MAX_OUT       = 8;

  // ==========================================================
  // decoded register selectors
  localparam logic [3:0] SEL_THR   = 4'h8;
  localparam logic [3:0] SEL_BAND  = 4'h9;
  localparam logic [3:0] SEL_STAT  = 4'hA;
  localparam logic [3:0] SEL_NONE  = 4'hF;

  // ==========================================================
  // function codes
  localparam logic [7:0] FC_NONE     = 8'h00;
  localparam logic [7:0] FC_SET_MATCH = 8'h01;
  localparam logic [7:0] FC_SPLIT    = 8'h04;
  localparam logic [7:0] FC_OVERLOAD = 8'h05;
  localparam logic [7:0] FC_INV_OC   = 8'h06;
  localparam logic [7:0] FC_UNDERLD  = 8'h07;
  localparam logic [7:0] FC_FAN      = 8'h08;
  localparam logic [7:0] FC_STALL    = 8'h09;
  localparam logic [7:0] FC_OVERVOLT = 8'h0A;
  localparam logic [7:0] FC_LOWVOLT  = 8'h0B;
  localparam logic [7:0] FC_OVERHEAT = 8'h0C;
  localparam logic [7:0] FC_CMD_LOST = 8'h0D;

  // ==========================================================
  // values after reset (frequencies in 0.01 Hz)
  localparam logic [7:0]  RST_CODE_RELAY1 = 8'h1C;
  localparam logic [7:0]  RST_CODE_RELAY2 = 8'h0E;
  localparam logic [7:0]  RST_CODE_TRANS  = 8'h01;
  localparam logic [7:0]  RST_CODE_OTHER  = 8'h00;
  localparam logic [15:0] RST_THR         = 16'h0BB8;
  localparam logic [15:0] RST_BAND        = 16'h03E8;

  // ==========================================================
  // bus responses and channel states
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OFS_W_IDLE = 2'h0,
    OFS_W_RESP = 2'h1
  } ofs_wst_t;

  typedef enum logic [1:0] {
    OFS_R_IDLE = 2'h0,
    OFS_R_DATA = 2'h1
  } ofs_rst_t;

endpackage
`default_nettype wire

// ===== src/ofs_output_function_selector.sv
// Our own choices: the address map and the AXI4-Lite register port.
`default_nettype none
module ofs_output_function_selector
  import ofs_pkg::*;
#(
  parameter int NUM_OUT = 6
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [15:0]          set_freq,
  input  wire logic [15:0]          oper_freq,
  input  wire logic                 accelerating,
  input  wire logic                 decelerating,
  input  wire logic                 motor_overload,
  input  wire logic                 inverse_time_overcurrent,
  input  wire logic                 underload_warn,
  input  wire logic                 fan_warn,
  input  wire logic                 motor_stall,
  input  wire logic                 dc_over_voltage,
  input  wire logic                 dc_low_voltage,
  input  wire logic                 inverter_overheat,
  input  wire logic                 analog_cmd_lost,
  input  wire logic                 serial_cmd_lost,
  output logic [NUM_OUT-1:0]        func_out
);

  // ==========================================================
  // parameter check
  if (NUM_OUT < 1 || NUM_OUT > MAX_OUT) begin : g_bad_num_out
    $error("NUM_OUT must lie between 1 and 8");
  end

  // ==========================================================
  // state
  typedef struct packed {
    ofs_wst_t                  wst;
    ofs_rst_t                  rst;
    logic [1:0]                bresp;
    logic [1:0]                rresp;
    logic [31:0]               rdata;
    logic [NUM_OUT-1:0][7:0]   code;
    logic [15:0]               thr;
    logic [15:0]               band;
    logic [NUM_OUT-1:0]        outs;
  } ofs_state_t;

  ofs_state_t st_ff;
  ofs_state_t nxt_st;

  // ==========================================================
  // helpers
  function automatic logic [3:0] ofs_decode(input logic [7:0] addr);
    logic [3:0] sel;
    sel = SEL_NONE;
    if (addr[7:2] < 6'(MAX_OUT)) begin
      if (int'(addr[7:2]) < NUM_OUT) begin
        sel = addr[5:2];
      end
    end else if (addr[7:2] == THR_OFS[7:2]) begin
      sel = SEL_THR;
    end else if (addr[7:2] == BAND_OFS[7:2]) begin
      sel = SEL_BAND;
    end else if (addr[7:2] == STAT_OFS[7:2]) begin
      sel = SEL_STAT;
    end
    return sel;
  endfunction

  function automatic logic [15:0] ofs_merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  function automatic logic [7:0] ofs_rst_code(input int idx);
    logic [7:0] c;
    unique case (idx)
      0:       c = RST_CODE_RELAY1;
      1:       c = RST_CODE_RELAY2;
      2:       c = RST_CODE_TRANS;
      default: c = RST_CODE_OTHER;
    endcase
    return c;
  endfunction

  // ==========================================================
  // frequency comparisons (17 bits, no wrap)
  logic [15:0] half_band;
  logic [16:0] freq_diff;
  logic        set_match;
  logic        at_or_above;
  logic        above_low;

  always_comb begin
    half_band   = {1'b0, st_ff.band[15:1]};
    freq_diff   = (set_freq >= oper_freq) ? 17'(set_freq - oper_freq)
                                          : 17'(oper_freq - set_freq);
    set_match   = freq_diff < {1'b0, half_band};
    at_or_above = oper_freq >= st_ff.thr;
    above_low   = ({1'b0, oper_freq} + {1'b0, half_band})
                  > {1'b0, st_ff.thr};
  end

  // ==========================================================
  // output function evaluation
  function automatic logic ofs_eval(
    input logic [7:0] code,
    input logic       prev
  );
    logic res;
    res = 1'b0;
    unique case (code)
      FC_SET_MATCH: res = set_match;
      FC_SPLIT: begin
        if (accelerating) begin
          res = at_or_above;
        end else if (decelerating) begin
          res = above_low;
        end else begin
          res = prev;
        end
      end
      FC_OVERLOAD: res = motor_overload;
      FC_INV_OC:   res = inverse_time_overcurrent;
      FC_UNDERLD:  res = underload_warn;
      FC_FAN:      res = fan_warn;
      FC_STALL:    res = motor_overload & motor_stall;
      FC_OVERVOLT: res = dc_over_voltage;
      FC_LOWVOLT:  res = dc_low_voltage;
      FC_OVERHEAT: res = inverter_overheat;
      FC_CMD_LOST: res = analog_cmd_lost | serial_cmd_lost;
      default:     res = 1'b0;
    endcase
    return res;
  endfunction

  // ==========================================================
  // next state
  logic       wr_take;
  logic       rd_take;
  logic [3:0] wsel;
  logic [3:0] rsel;

  always_comb begin
    nxt_st  = st_ff;
    wsel    = ofs_decode(s_axi_awaddr);
    rsel    = ofs_decode(s_axi_araddr);
    wr_take = (st_ff.wst == OFS_W_IDLE) & s_axi_awvalid & s_axi_wvalid;
    rd_take = (st_ff.rst == OFS_R_IDLE) & s_axi_arvalid;

    // outputs follow their codes every cycle
    for (int i = 0; i < NUM_OUT; i++) begin
      nxt_st.outs[i] = ofs_eval(st_ff.code[i], st_ff.outs[i]);
    end

    // write channel
    unique case (st_ff.wst)
      OFS_W_IDLE: begin
        if (wr_take) begin
          nxt_st.wst   = OFS_W_RESP;
          nxt_st.bresp = RESP_OKAY;
          if (wsel < 4'(MAX_OUT)) begin
            if (s_axi_wstrb[0]) begin
              nxt_st.code[wsel[2:0]] = s_axi_wdata[7:0];
            end
          end else if (wsel == SEL_THR) begin
            nxt_st.thr = ofs_merge16(st_ff.thr, s_axi_wdata,
                                     s_axi_wstrb);
          end else if (wsel == SEL_BAND) begin
            nxt_st.band = ofs_merge16(st_ff.band, s_axi_wdata,
                                      s_axi_wstrb);
          end else if (wsel != SEL_STAT) begin
            nxt_st.bresp = RESP_SLVERR;
          end
        end
      end
      OFS_W_RESP: begin
        if (s_axi_bready) begin
          nxt_st.wst = OFS_W_IDLE;
        end
      end
      default: nxt_st.wst = OFS_W_IDLE;
    endcase

    // read channel
    unique case (st_ff.rst)
      OFS_R_IDLE: begin
        if (rd_take) begin
          nxt_st.rst   = OFS_R_DATA;
          nxt_st.rresp = RESP_OKAY;
          nxt_st.rdata = 32'h0000_0000;
          if (rsel < 4'(MAX_OUT)) begin
            nxt_st.rdata[7:0] = st_ff.code[rsel[2:0]];
          end else if (rsel == SEL_THR) begin
            nxt_st.rdata[15:0] = st_ff.thr;
          end else if (rsel == SEL_BAND) begin
            nxt_st.rdata[15:0] = st_ff.band;
          end else if (rsel == SEL_STAT) begin
            nxt_st.rdata[NUM_OUT-1:0] = st_ff.outs;
          end else begin
            nxt_st.rresp = RESP_SLVERR;
          end
        end
      end
      OFS_R_DATA: begin
        if (s_axi_rready) begin
          nxt_st.rst = OFS_R_IDLE;
        end
      end
      default: nxt_st.rst = OFS_R_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff.wst   <= OFS_W_IDLE;
      st_ff.rst   <= OFS_R_IDLE;
      st_ff.bresp <= RESP_OKAY;
      st_ff.rresp <= RESP_OKAY;
      st_ff.rdata <= 32'h0000_0000;
      for (int i = 0; i < NUM_OUT; i++) begin
        st_ff.code[i] <= ofs_rst_code(i);
      end
      st_ff.thr   <= RST_THR;
      st_ff.band  <= RST_BAND;
      st_ff.outs  <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // ports
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_bvalid  = (st_ff.wst == OFS_W_RESP);
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = (st_ff.rst == OFS_R_IDLE);
  assign s_axi_rvalid  = (st_ff.rst == OFS_R_DATA);
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign func_out      = st_ff.outs;

endmodule
`default_nettype wire

// ===== verif/ofs_load_model.sv
`default_nettype none
module ofs_load_model #(
  parameter int NUM_OUT = 6
) (
  input  wire logic [NUM_OUT-1:0] drive,
  input  wire logic               aclk,
  output logic      [NUM_OUT-1:0] energized
);
  timeunit 1ns;
  timeprecision 1ns;
  // coil picks up one clock after drive
  always_ff @(posedge aclk) begin
    energized <= drive;
  end
endmodule
`default_nettype wire

// ===== verif/ofs_output_function_selector_chk.sv
`default_nettype none
module ofs_output_function_selector_chk
  import ofs_pkg::*;
#(
  parameter int NUM_OUT = 6
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [7:0]         s_axi_awaddr,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic [31:0]        s_axi_wdata,
  input wire logic [3:0]         s_axi_wstrb,
  input wire logic               s_axi_wvalid,
  input wire logic [15:0]        oper_freq,
  input wire logic               accelerating,
  input wire logic               motor_overload,
  input wire logic               inverse_time_overcurrent,
  input wire logic               motor_stall,
  input wire logic               dc_over_voltage,
  input wire logic               inverter_overheat,
  input wire logic               analog_cmd_lost,
  input wire logic               serial_cmd_lost,
  input wire logic [NUM_OUT-1:0] func_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // mirror of output 0 code and threshold
  logic [7:0]  code_ff;
  logic [15:0] thr_ff;
  wire logic   take = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_ff <= RST_CODE_RELAY1;
      thr_ff  <= RST_THR;
    end else if (take && s_axi_awaddr[7:2] == CODE_BASE_OFS[7:2]) begin
      if (s_axi_wstrb[0]) begin
        code_ff <= s_axi_wdata[7:0];
      end
    end else if (take && s_axi_awaddr[7:2] == THR_OFS[7:2]) begin
      if (s_axi_wstrb[0]) begin
        thr_ff[7:0] <= s_axi_wdata[7:0];
      end
      if (s_axi_wstrb[1]) begin
        thr_ff[15:8] <= s_axi_wdata[15:8];
      end
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // output 0 against its code
  property p_acc;
    code_ff == FC_SPLIT && accelerating |=> func_out[0] == ($past(oper_freq) >= $past(thr_ff));
  endproperty
  a_acc: assert property (p_acc) else $error("split accel wrong");
  property p_ovl;
    code_ff == FC_OVERLOAD |=> func_out[0] == $past(motor_overload);
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload wrong");
  property p_iol;
    code_ff == FC_INV_OC |=> func_out[0] == $past(inverse_time_overcurrent);
  endproperty
  a_iol: assert property (p_iol) else $error("overcurrent wrong");
  property p_stl;
    code_ff == FC_STALL |=> func_out[0] == ($past(motor_overload) && $past(motor_stall));
  endproperty
  a_stl: assert property (p_stl) else $error("stall wrong");
  property p_ovv;
    code_ff == FC_OVERVOLT ##1 1'b1 |-> func_out[0] == $past(dc_over_voltage);
  endproperty
  a_ovv: assert property (p_ovv) else $error("overvoltage wrong");
  property p_hot;
    code_ff == FC_OVERHEAT ##1 $past(inverter_overheat) |-> func_out[0];
  endproperty
  a_hot: assert property (p_hot) else $error("overheat wrong");
  property p_lst;
    code_ff == FC_CMD_LOST && (analog_cmd_lost || serial_cmd_lost) |=> func_out[0];
  endproperty
  a_lst: assert property (p_lst) else $error("command lost wrong");
  property p_off;
    code_ff inside {8'h00, 8'h02, 8'h03} || code_ff > FC_CMD_LOST |=> !func_out[0];
  endproperty
  a_off: assert property (p_off) else $error("unsupported code drives");
endmodule
bind ofs_output_function_selector ofs_output_function_selector_chk #(.NUM_OUT(NUM_OUT)) i_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .oper_freq, .accelerating, .motor_overload, .inverse_time_overcurrent,
  .motor_stall, .dc_over_voltage, .inverter_overheat, .analog_cmd_lost, .serial_cmd_lost,
  .func_out);
`default_nettype wire

// ===== verif/ofs_output_function_selector_tb.sv
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
module ofs_output_function_selector_tb
  import ofs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, accelerating, decelerating;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] set_freq, oper_freq;
  logic [9:0]  st, pat;
  logic [5:0]  func_out, energized;
  int          miscompares, compares, cyc;
  ofs_output_function_selector #(.NUM_OUT(6)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .set_freq, .oper_freq,
    .accelerating, .decelerating, .motor_overload(st[0]), .inverse_time_overcurrent(st[1]),
    .underload_warn(st[2]), .fan_warn(st[3]), .motor_stall(st[4]), .dc_over_voltage(st[5]),
    .dc_low_voltage(st[6]), .inverter_overheat(st[7]), .analog_cmd_lost(st[8]),
    .serial_cmd_lost(st[9]), .func_out);
  ofs_load_model #(.NUM_OUT(6)) i_load (.drive(func_out), .aclk, .energized);
  always #50 aclk = ~aclk;
  // ==========
  // bus tasks and expectations
  task automatic final_report();
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", e, s_axi_bresp)
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("rresp", e, s_axi_rresp)
    `CHK("rdata", d, s_axi_rdata)
  endtask
  task automatic fq(logic a, logic d, logic [15:0] sf, logic [15:0] of, logic [2:0] e);
    @(posedge aclk);
    accelerating <= a;
    decelerating <= d;
    set_freq <= sf;
    oper_freq <= of;
    repeat (2) @(posedge aclk);
    #1 `CHK("func_out", e, func_out[2:0])
    @(posedge aclk);
    #1 `CHK("load", e, energized[2:0])
  endtask
  function automatic logic fx(logic [7:0] c, logic [9:0] s);
    case (c)
      FC_OVERLOAD: return s[0];
      FC_INV_OC:   return s[1];
      FC_UNDERLD:  return s[2];
      FC_FAN:      return s[3];
      FC_STALL:    return s[0] & s[4];
      FC_OVERVOLT: return s[5];
      FC_LOWVOLT:  return s[6];
      FC_OVERHEAT: return s[7];
      FC_CMD_LOST: return s[8] | s[9];
      default:     return 1'b0;
    endcase
  endfunction
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // ==========
  // main sequence
  initial begin
    {aclk, aresetn, accelerating, decelerating, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, set_freq, oper_freq, st} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0000001C, RESP_OKAY);
    rd(8'h04, 32'h0000000E, RESP_OKAY);
    rd(8'h08, 32'h00000001, RESP_OKAY);
    rd(8'h14, 32'h00000000, RESP_OKAY);
    rd(THR_OFS, 32'h00000BB8, RESP_OKAY);
    rd(BAND_OFS, 32'h000003E8, RESP_OKAY);
    rd(8'h18, 32'h00000000, RESP_SLVERR);
    wr(8'h30, 32'h00000005, 4'hF, RESP_SLVERR);
    wr(STAT_OFS, 32'h0000003F, 4'hF, RESP_OKAY);
    for (int c = 0; c < 15; c++) begin
      if (c != 1 && c != 4) begin
        wr(CODE_BASE_OFS, 32'(c), 4'hF, RESP_OKAY);
        for (int k = 0; k < 11; k++) begin
          pat = (k == 10) ? 10'h011 : 10'h001 << k;
          @(posedge aclk);
          st <= pat;
          repeat (2) @(posedge aclk);
          #1 `CHK("func_out0", fx(8'(c), pat), func_out[0])
        end
      end
    end
    wr(THR_OFS, 32'hFFFF07D0, 4'h1, RESP_OKAY);
    rd(THR_OFS, 32'h00000BD0, RESP_OKAY);
    wr(THR_OFS, 32'hFFFF07D0, 4'hF, RESP_OKAY);
    wr(BAND_OFS, 32'h00000190, 4'hF, RESP_OKAY);
    wr(CODE_BASE_OFS, 32'(FC_SPLIT), 4'hF, RESP_OKAY);
    fq(1'b1, 1'b0, 16'h0897, 16'h07D0, 3'b101);
    fq(1'b1, 1'b0, 16'h0897, 16'h07CF, 3'b000);
    fq(1'b0, 1'b1, 16'h0642, 16'h0709, 3'b101);
    fq(1'b0, 1'b1, 16'h0640, 16'h0708, 3'b000);
    fq(1'b1, 1'b1, 16'h0000, 16'h0750, 3'b000);
    fq(1'b0, 1'b1, 16'h0000, 16'h0750, 3'b001);
    rd(STAT_OFS, 32'h00000001, RESP_OKAY);
    fq(1'b0, 1'b0, 16'h0000, 16'h0000, 3'b101);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1 `CHK("func_out_rst", 6'h00, func_out)
    rd(CODE_BASE_OFS, 32'h0000001C, RESP_OKAY);
    rd(THR_OFS, 32'h00000BB8, RESP_OKAY);
    rd(STAT_OFS, 32'h00000004, RESP_OKAY);
    final_report();
  end
endmodule
`default_nettype wire
